// file: common/dnf_pkg.sv
// Overview of operation
// - Each enabled stage notches its centre frequency
// - Higher Q gives narrower, sharper notch
// - Lowest enable digit 1 turns stage one on
// - Third enable digit 1 turns stage two on
// - Stage one frequency 50..5000 Hz, reset 5000
// - Stage one Q 50..1000 (x0.01), reset 70
// - Stage one depth 0..1000 (x0.001), reset 0
// - Stage two frequency 50..5000 Hz, reset 5000
// - Stage two Q 50..1000 (x0.01), reset 70
// - Stage two depth 0..1000 (x0.001), reset 0
// - Stages run in series, each independent
package dnf_pkg;
    // Register offsets
    localparam logic [3:0] REG_ENABLES = 4'h0;
    localparam logic [3:0] REG_S1_FREQ = 4'h1;
    localparam logic [3:0] REG_S1_Q = 4'h2;
    localparam logic [3:0] REG_S1_DEPTH = 4'h3;
    localparam logic [3:0] REG_S2_FREQ = 4'h4;
    localparam logic [3:0] REG_S2_Q = 4'h5;
    localparam logic [3:0] REG_S2_DEPTH = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    // Reset values
    localparam logic [15:0] RST_ENABLES = 16'h0000;
    localparam logic [15:0] RST_FREQ = 16'h1388;
    localparam logic [15:0] RST_Q = 16'h0046;
    localparam logic [15:0] RST_DEPTH = 16'h0000;
    // Legal setting ranges
    localparam logic [15:0] FREQ_MIN = 16'h0032;
    localparam logic [15:0] FREQ_MAX = 16'h1388;
    localparam logic [15:0] Q_MIN = 16'h0032;
    localparam logic [15:0] Q_MAX = 16'h03E8;
    localparam logic [15:0] DEPTH_MIN = 16'h0000;
    localparam logic [15:0] DEPTH_MAX = 16'h03E8;
    // Enable selector digit positions and the "on" digit
    localparam int EN1_LSB = 0;
    localparam int EN2_LSB = 8;
    localparam logic [3:0] DIGIT_ON = 4'h1;
    // Fixed point: damping 100/Q in Q2.14, tuning f in Q24, gain Q16
    localparam int Q_FRAC = 14;
    localparam int F_FRAC = 24;
    localparam int G_FRAC = 16;
    localparam int STATE_SHIFT = 8;
    localparam logic [20:0] Q_NUM = 21'h190000;
    localparam logic [31:0] TWO_PI_Q24 = 32'h06487ED5;
    localparam logic [31:0] DEPTH_RECIP_Q24 = 32'h00004189;
    localparam logic [4:0] DIV_STEPS = 5'h15;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_CALC, ST_OUT} dnf_state_t;
    // Clamp a written setting into its legal range
    function automatic logic [15:0] dnf_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        dnf_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
endpackage : dnf_pkg

// file: common/dnf_stream_if.sv
// Valid/ready sample stream between the block's own modules
interface dnf_stream_if #(parameter int W = 16);
    logic [W-1:0] data; // Sample word
    logic valid; // Word present
    logic ready; // Sink accepts
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : dnf_stream_if

// file: rtl/dnf_fifo.sv
// Sample FIFO; write side ready is registered
module dnf_fifo import dnf_pkg::*; #(
    parameter int W = 16,
    parameter int DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Streams
    dnf_stream_if.snk wr,
    dnf_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    // Refuse depths that the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two");
    end
    logic [W-1:0] mem [DEPTH]; // Storage
    logic [AW-1:0] wptr_r; // Write pointer
    logic [AW-1:0] rptr_r; // Read pointer
    logic [AW:0] count_r; // Fill level
    logic [AW:0] count_nxt;
    logic ready_r; // Registered not-full
    logic push;
    logic pop;
    assign push = wr.valid && ready_r;
    assign pop = rd.ready && (count_r != '0);
    assign wr.ready = ready_r;
    assign rd.valid = (count_r != '0);
    assign rd.data = mem[rptr_r];
    // Next fill level
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end
    // Pointers, level and ready
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
            ready_r <= 1'b0;
        end else if (ce) begin
            if (push) wptr_r <= wptr_r + 1'b1;
            if (pop) rptr_r <= rptr_r + 1'b1;
            count_r <= count_nxt;
            ready_r <= (count_nxt < (AW + 1)'(DEPTH));
        end
    end
    // Storage write
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem[wptr_r] <= wr.data;
        end
    end
    a_no_overfill: assert property (@(posedge clk_sys) disable iff (!resetn)
        count_r <= (AW + 1)'(DEPTH)) else $error("FIFO level above depth");
endmodule // dnf_fifo

// file: rtl/dnf_top.sv
// Dual notch filter on the torque reference stream
//
// The plain strobed port and the register offsets are this design's own decisions.
module dnf_top import dnf_pkg::*; #(
    parameter int FS_HZ = 100000,
    parameter int W = 16,
    parameter int FIFO_DEPTH = 32
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Torque reference in
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Filtered torque reference out
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    // Refuse parameters that the fixed-point scaling cannot serve
    if (FS_HZ < 20000 || FS_HZ > 10000000) begin : g_bad_fs
        $error("FS_HZ out of serviceable range");
    end
    if (W < 8 || W > 20) begin : g_bad_w
        $error("W must be 8..20");
    end
    // Tuning gain per hertz in Q24
    localparam logic [31:0] F_PER_HZ = TWO_PI_Q24 / 32'(FS_HZ);

    // Settings registers
    logic [15:0] enables_r; // Enable selector
    logic [15:0] freq_r [2]; // Centre frequency, Hz
    logic [15:0] q_r [2]; // Q, x0.01
    logic [15:0] depth_r [2]; // Depth, x0.001
    logic [15:0] rdata_r; // Read data
    // Sample-boundary snapshot
    logic [1:0] snap_en_r;
    logic [15:0] snap_freq_r [2];
    logic [15:0] snap_q_r [2];
    logic [15:0] snap_depth_r [2];
    // Sequencer
    dnf_state_t state_r;
    logic stage_r; // Stage in work
    logic [4:0] cnt_r; // Divider steps left
    logic [21:0] rem_r; // Divider remainder
    logic [20:0] num_r; // Divider dividend
    logic [20:0] quo_r; // Damping 100/Q, Q2.14
    // Datapath state
    logic signed [31:0] acc_r; // Sample through cascade, scaled
    logic signed [31:0] bp_r [2]; // Band-pass integrators
    logic signed [31:0] lp_r [2]; // Low-pass integrators
    logic [W-1:0] x_in_r; // Raw input sample
    logic out_valid_r;
    logic [W-1:0] out_data_r;
    // FIFO
    dnf_stream_if #(.W(W)) fin ();
    dnf_stream_if #(.W(W)) fout ();

    assign fin.data = in_data;
    assign fin.valid = in_valid;
    assign in_ready = fin.ready;
    assign reg_rdata = rdata_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    // Input buffering; the sequencer drains it
    dnf_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .wr(fin),
        .rd(fout)
    );

    // Pop one word when idle and output slot free
    logic take;
    assign take = (state_r == ST_IDLE) && fout.valid && !out_valid_r;
    assign fout.ready = ce && take;

    // Settings writes, clamped into range
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            enables_r <= RST_ENABLES;
            freq_r[0] <= RST_FREQ;
            freq_r[1] <= RST_FREQ;
            q_r[0] <= RST_Q;
            q_r[1] <= RST_Q;
            depth_r[0] <= RST_DEPTH;
            depth_r[1] <= RST_DEPTH;
        end else if (ce && reg_wr) begin
            unique case (reg_addr)
                REG_ENABLES: enables_r <= reg_wdata;
                REG_S1_FREQ: freq_r[0] <= dnf_clamp(reg_wdata, FREQ_MIN, FREQ_MAX);
                REG_S1_Q: q_r[0] <= dnf_clamp(reg_wdata, Q_MIN, Q_MAX);
                REG_S1_DEPTH: depth_r[0] <= dnf_clamp(reg_wdata, DEPTH_MIN, DEPTH_MAX);
                REG_S2_FREQ: freq_r[1] <= dnf_clamp(reg_wdata, FREQ_MIN, FREQ_MAX);
                REG_S2_Q: q_r[1] <= dnf_clamp(reg_wdata, Q_MIN, Q_MAX);
                REG_S2_DEPTH: depth_r[1] <= dnf_clamp(reg_wdata, DEPTH_MIN, DEPTH_MAX);
                default: ; // Status and unmapped: ignored
            endcase
        end
    end

    // Register reads, data one cycle later
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
        end else if (ce) begin
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_ENABLES: rdata_r <= enables_r;
                    REG_S1_FREQ: rdata_r <= freq_r[0];
                    REG_S1_Q: rdata_r <= q_r[0];
                    REG_S1_DEPTH: rdata_r <= depth_r[0];
                    REG_S2_FREQ: rdata_r <= freq_r[1];
                    REG_S2_Q: rdata_r <= q_r[1];
                    REG_S2_DEPTH: rdata_r <= depth_r[1];
                    REG_STATUS: rdata_r <= {12'h000, out_valid_r, state_r != ST_IDLE, snap_en_r};
                    default: rdata_r <= 16'h0000;
                endcase
            end else begin
                rdata_r <= 16'h0000;
            end
        end
    end

    // Snapshot all settings as a sample is taken
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            snap_en_r <= 2'b00;
            for (int i = 0; i < 2; i++) begin
                snap_freq_r[i] <= RST_FREQ;
                snap_q_r[i] <= RST_Q;
                snap_depth_r[i] <= RST_DEPTH;
            end
        end else if (ce && take) begin
            snap_en_r[0] <= (enables_r[EN1_LSB +: 4] == DIGIT_ON);
            snap_en_r[1] <= (enables_r[EN2_LSB +: 4] == DIGIT_ON);
            for (int i = 0; i < 2; i++) begin
                snap_freq_r[i] <= freq_r[i];
                snap_q_r[i] <= q_r[i];
                snap_depth_r[i] <= depth_r[i];
            end
        end
    end

    // Stage arithmetic: state-variable notch
    logic signed [63:0] f_w, q_w, g_w, qbp_w, hp_w, bpn_w, lpn_w, y_w;
    always_comb begin
        f_w = 64'(snap_freq_r[stage_r]) * 64'(F_PER_HZ);
        q_w = 64'(quo_r);
        g_w = ((64'(DEPTH_MAX) - 64'(snap_depth_r[stage_r])) * 64'(DEPTH_RECIP_Q24))
              >>> (F_FRAC - G_FRAC);
        qbp_w = (q_w * 64'(bp_r[stage_r])) >>> Q_FRAC;
        hp_w = 64'(acc_r) - 64'(lp_r[stage_r]) - qbp_w;
        bpn_w = 64'(bp_r[stage_r]) + ((f_w * hp_w) >>> F_FRAC);
        lpn_w = 64'(lp_r[stage_r]) + ((f_w * bpn_w) >>> F_FRAC);
        y_w = 64'(acc_r) - ((g_w * qbp_w) >>> G_FRAC);
    end

    // Saturate the scaled cascade result to the output width
    localparam logic signed [31:0] OUT_MAX = 32'((1 << (W - 1)) - 1);
    localparam logic signed [31:0] OUT_MIN = -32'(1 << (W - 1));
    logic signed [31:0] y_sc;
    assign y_sc = acc_r >>> STATE_SHIFT;

    // Sequencer: divide, calc per stage, then present
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            stage_r <= 1'b0;
            cnt_r <= 5'h00;
            rem_r <= '0;
            num_r <= '0;
            quo_r <= '0;
            acc_r <= '0;
            x_in_r <= '0;
        end else if (ce) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        x_in_r <= fout.data;
                        acc_r <= 32'(signed'(fout.data)) <<< STATE_SHIFT;
                        stage_r <= 1'b0;
                        state_r <= ST_DIV;
                        cnt_r <= DIV_STEPS;
                        rem_r <= '0;
                        num_r <= Q_NUM;
                        quo_r <= '0;
                    end
                end
                ST_DIV: begin
                    // Restoring division 100/Q
                    if ({rem_r[20:0], num_r[20]} >= 22'(snap_q_r[stage_r])) begin
                        rem_r <= {rem_r[20:0], num_r[20]} - 22'(snap_q_r[stage_r]);
                        quo_r <= {quo_r[19:0], 1'b1};
                    end else begin
                        rem_r <= {rem_r[20:0], num_r[20]};
                        quo_r <= {quo_r[19:0], 1'b0};
                    end
                    num_r <= {num_r[19:0], 1'b0};
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) state_r <= ST_CALC;
                end
                ST_CALC: begin
                    if (snap_en_r[stage_r]) acc_r <= 32'(y_w);
                    if (stage_r) begin
                        state_r <= ST_OUT;
                    end else begin
                        stage_r <= 1'b1;
                        state_r <= ST_DIV;
                        cnt_r <= DIV_STEPS;
                        rem_r <= '0;
                        num_r <= Q_NUM;
                        quo_r <= '0;
                    end
                end
                ST_OUT: state_r <= ST_IDLE;
            endcase
        end
    end

    // Filter integrators; cleared while a stage is bypassed
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            for (int i = 0; i < 2; i++) begin
                bp_r[i] <= '0;
                lp_r[i] <= '0;
            end
        end else if (ce && state_r == ST_CALC) begin
            if (snap_en_r[stage_r]) begin
                bp_r[stage_r] <= 32'(bpn_w);
                lp_r[stage_r] <= 32'(lpn_w);
            end else begin
                bp_r[stage_r] <= '0;
                lp_r[stage_r] <= '0;
            end
        end
    end

    // Output holding register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (ce) begin
            if (state_r == ST_OUT) begin
                out_valid_r <= 1'b1;
                if (y_sc > OUT_MAX) out_data_r <= OUT_MAX[W-1:0];
                else if (y_sc < OUT_MIN) out_data_r <= OUT_MIN[W-1:0];
                else out_data_r <= y_sc[W-1:0];
            end else if (out_ready) begin
                out_valid_r <= 1'b0;
            end
        end
    end

    // Checks
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_freq1_range: assert property (freq_r[0] >= FREQ_MIN && freq_r[0] <= FREQ_MAX)
        else $error("Stage one frequency out of range");
    a_q1_range: assert property (q_r[0] >= Q_MIN && q_r[0] <= Q_MAX)
        else $error("Stage one Q out of range");
    a_depth1_range: assert property (depth_r[0] <= DEPTH_MAX)
        else $error("Stage one depth out of range");
    a_freq2_range: assert property (ce && reg_wr && reg_addr == REG_S2_FREQ |=>
        freq_r[1] == dnf_clamp($past(reg_wdata), FREQ_MIN, FREQ_MAX))
        else $error("Stage two frequency write not clamped");
    a_q2_range: assert property (ce && reg_wr && reg_addr == REG_S2_Q |=>
        q_r[1] == dnf_clamp($past(reg_wdata), Q_MIN, Q_MAX))
        else $error("Stage two Q write not clamped");
    a_depth2_range: assert property (depth_r[1] <= DEPTH_MAX)
        else $error("Stage two depth out of range");
    a_damping_quotient: assert property (state_r == ST_CALC |->
        (32'(quo_r) * 32'(snap_q_r[stage_r]) <= 32'(Q_NUM)) &&
        (32'(Q_NUM) - 32'(quo_r) * 32'(snap_q_r[stage_r]) < 32'(snap_q_r[stage_r])))
        else $error("Damping quotient wrong");
    a_stage1_bypass: assert property (ce && state_r == ST_CALC && !stage_r &&
        !snap_en_r[0] |=> $stable(acc_r)) else $error("Disabled stage one altered sample");
    a_stage2_bypass: assert property (ce && state_r == ST_CALC && stage_r &&
        !snap_en_r[1] |=> $stable(acc_r)) else $error("Disabled stage two altered sample");
    a_full_depth_pass: assert property (ce && state_r == ST_CALC &&
        snap_depth_r[stage_r] == DEPTH_MAX |=> $stable(acc_r))
        else $error("Full depth stage altered sample");
    a_cascade_order: assert property (ce && state_r == ST_CALC && !stage_r |=>
        state_r == ST_DIV && stage_r) else $error("Stage two not following stage one");
    a_snap_atomic: assert property (state_r != ST_IDLE && !take |=>
        $stable(snap_en_r) && $stable(snap_q_r[0]) && $stable(snap_q_r[1]) &&
        $stable(snap_freq_r[0]) && $stable(snap_depth_r[1]) &&
        $stable(snap_freq_r[1]) && $stable(snap_depth_r[0]))
        else $error("Settings changed mid sample");
    a_bypass_exact: assert property (ce && state_r == ST_OUT && snap_en_r == 2'b00 |=>
        out_valid_r && out_data_r == x_in_r) else $error("Bypassed sample not exact");

    c_both_on: cover property (ce && state_r == ST_OUT && snap_en_r == 2'b11);
    c_only_two: cover property (ce && state_r == ST_OUT && snap_en_r == 2'b10);
    c_fifo_stall: cover property (in_valid && !in_ready);
endmodule // dnf_top

// file: tb/dnf_stream_model.sv
// Speed loop source and current amplifier sink around the filter
module dnf_stream_model #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Torque reference towards the filter
    output logic in_valid,
    output logic [W-1:0] in_data,
    input wire logic in_ready,
    // Filtered torque reference from the filter
    input wire logic out_valid,
    input wire logic [W-1:0] out_data,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] tx_q[$]; // Samples still to send
    logic [W-1:0] rx_q[$]; // Samples received
    logic stall; // Sink refuses everything
    logic slow; // Sink accepts on random cycles, one in four on average
    int accepted; // Samples taken by the filter
    initial begin
        in_valid = 1'b0;
        in_data = '0;
        out_ready = 1'b0;
        stall = 1'b0;
        slow = 1'b0;
        accepted = 0;
    end
    // Source holds each word until taken; idle line toggles
    always @(posedge clk_sys) begin
        if (!resetn) begin
            in_valid <= 1'b0;
        end else begin
            if (in_valid && in_ready) begin
                tx_q.delete(0);
                accepted++;
            end
            in_valid <= (tx_q.size() > 0);
            in_data <= (tx_q.size() > 0) ? tx_q[0] : ~in_data;
        end
    end
    // Sink collects words, stalling as told
    always @(posedge clk_sys) begin
        if (out_valid && out_ready && resetn) begin
            rx_q.push_back(out_data);
        end
        out_ready <= resetn && !stall && (!slow || ($urandom_range(3, 0) == 0));
    end
endmodule // dnf_stream_model

// file: tb/dual_notch_torque_filter_tb_top.sv
// Self-checking bench for the dual notch filter
module dual_notch_torque_filter_tb_top import dnf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FS = 20000; // Sample rate used for tuning
    logic clk_sys, resetn, ce, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, in_data, out_data, rd;
    int n_mismatch, checked;
    dnf_top #(.FS_HZ(FS), .W(16), .FIFO_DEPTH(32)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    dnf_stream_model #(.W(16)) partner (
        .clk_sys(clk_sys), .resetn(resetn), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    // Clock at 50 MHz
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Compare seen against expected
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("counts: %0d compared, %0d mismatched", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One-cycle register write
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // One-cycle register read, data taken in the following cycle
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Bounded wait for n received words
    task automatic wait_out(input int n);
        int i;
        for (i = 0; i < 60 * n + 400 && partner.rx_q.size() < n; i++) @(posedge clk_sys);
        if (partner.rx_q.size() < n) begin
            n_mismatch++;
            $display("MISMATCH output count expected %0d seen %0d", n, partner.rx_q.size());
            complete_run();
        end
    endtask
    // Expected value of a clamped write
    function automatic logic [15:0] fit(input logic [15:0] v, input logic [3:0] a);
        logic [15:0] lo, hi;
        lo = (a == 1 || a == 4) ? FREQ_MIN : ((a == 2 || a == 5) ? Q_MIN : DEPTH_MIN);
        hi = (a == 1 || a == 4) ? FREQ_MAX : ((a == 2 || a == 5) ? Q_MAX : DEPTH_MAX);
        fit = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // Sine through the filter; ratio of output peak to input amplitude in percent
    task automatic run_sine(input logic [15:0] en, input logic [15:0] f1, input logic [15:0] f2,
                            input logic [15:0] q, input logic [15:0] d, input int period,
                            input int lo, input int hi);
        int k, peak, v;
        peak = 0;
        reg_write(4'h1, f1);
        reg_write(4'h4, f2);
        reg_write(4'h2, q);
        reg_write(4'h5, q);
        reg_write(4'h3, d);
        reg_write(4'h6, d);
        reg_write(4'h0, en);
        partner.rx_q.delete();
        for (k = 0; k < 120; k++) partner.tx_q.push_back(16'($rtoi(8000.0 * $sin(6.2831853 * k / period))));
        wait_out(120);
        for (k = 80; k < 120; k++) begin
            v = int'($signed(partner.rx_q[k]));
            if (v < 0) v = -v;
            if (v > peak) peak = v;
        end
        chk("notch peak ratio in band", (peak * 100 / 8000 >= lo) && (peak * 100 / 8000 <= hi), 1);
        $display("test sine en=%0h f1=%0d f2=%0d q=%0d depth=%0d done", en, f1, f2, q, d);
        reg_write(4'h0, 16'h0000);
    endtask
    // Watchdog
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
    // Main sequence
    initial begin
        logic [15:0] rst_tab[7];
        logic [15:0] en_tab[4];
        logic [15:0] v, w[$];
        int a, k, e;
        rst_tab = '{RST_ENABLES, RST_FREQ, RST_Q, RST_DEPTH, RST_FREQ, RST_Q, RST_DEPTH};
        en_tab = '{16'h0000, 16'h0202, 16'h1010, 16'hF0F0};
        n_mismatch = 0;
        checked = 0;
        ce = 1'b1;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(32));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, status, unmapped, read data standing one cycle
        for (a = 0; a < 7; a++) begin
            reg_read(a[3:0], rd);
            chk("reset value", rd, rst_tab[a]);
        end
        @(posedge clk_sys);
        #1 chk("rdata after read", reg_rdata, 16'h0000);
        reg_write(4'h7, 16'hFFFF);
        reg_write(4'hB, 16'h1234);
        // A write while the clock enable is low must not land
        ce <= 1'b0;
        reg_write(4'h1, 16'h0100);
        ce <= 1'b1;
        reg_read(4'h1, rd);
        chk("write under ce low", rd, RST_FREQ);
        reg_read(4'h7, rd);
        chk("status idle", rd, 16'h0000);
        reg_read(4'hB, rd);
        chk("unmapped read", rd, 16'h0000);
        $display("test reset values done");
        // Range clamping of every setting, corners and random
        for (a = 1; a < 7; a++) begin
            w = '{16'h0000, fit(16'h0000, a[3:0]) - 16'h0001, fit(16'h0000, a[3:0]),
                  fit(16'hFFFF, a[3:0]), fit(16'hFFFF, a[3:0]) + 16'h0001, 16'hFFFF,
                  16'($urandom), 16'($urandom_range(1000, 50))};
            foreach (w[k]) begin
                reg_write(a[3:0], w[k]);
                reg_read(a[3:0], rd);
                chk("setting readback", rd, fit(w[k], a[3:0]));
            end
        end
        v = 16'($urandom);
        reg_write(4'h0, v);
        reg_read(4'h0, rd);
        chk("enables readback", rd, v);
        $display("test setting ranges done");
        // Bypass for enable digits 0 and 2, with digits 1 and F only outside the enable positions
        foreach (en_tab[e]) begin
            reg_write(4'h0, en_tab[e]);
            partner.rx_q.delete();
            partner.slow = (e % 2 == 1);
            w.delete();
            for (k = 0; k < 12; k++) w.push_back(16'($urandom));
            foreach (w[k]) partner.tx_q.push_back(w[k]);
            wait_out(12);
            foreach (w[k]) chk("bypass sample", partner.rx_q[k], w[k]);
        end
        partner.slow = 1'b0;
        $display("test bypass done");
        // Buffer filled under a stalled sink, then drained in order
        reg_write(4'h0, 16'h0000);
        partner.rx_q.delete();
        partner.stall = 1'b1;
        partner.accepted = 0;
        w.delete();
        for (k = 0; k < 40; k++) w.push_back(16'($urandom));
        foreach (w[k]) partner.tx_q.push_back(w[k]);
        repeat (400) @(posedge clk_sys);
        #1 chk("accepted while stalled", partner.accepted, 33);
        chk("in_ready when full", in_ready, 1'b0);
        partner.stall = 1'b0;
        wait_out(40);
        foreach (w[k]) chk("drained sample", partner.rx_q[k], w[k]);
        $display("test buffer full done");
        // Notch responses
        run_sine(16'h0001, 16'h07D0, 16'h07D0, 16'h0032, 16'h0000, 10, 0, 35);
        run_sine(16'h0100, 16'h07D0, 16'h07D0, 16'h0032, 16'h0000, 10, 0, 35);
        run_sine(16'h0001, 16'h07D0, 16'h07D0, 16'h03E8, 16'h0000, 20, 85, 120);
        run_sine(16'h0001, 16'h07D0, 16'h07D0, 16'h0032, 16'h0000, 20, 0, 75);
        run_sine(16'h0001, 16'h07D0, 16'h07D0, 16'h0032, 16'h03E8, 10, 90, 120);
        run_sine(16'h0100, 16'h07D0, 16'h07D0, 16'h0032, 16'h03E8, 10, 90, 120);
        run_sine(16'h0101, 16'h01F4, 16'h07D0, 16'h0032, 16'h0000, 10, 0, 35);
        complete_run();
    end
endmodule // dual_notch_torque_filter_tb_top
